// ===== inc/adcsq_pkg.sv
// Constants for the conversion sequencer: register map, fields, timing.
// Assumes an 8-bit register port and a 20 MHz core clock.
// What this block does
// - Two bit periods rest after each conversion
// - Conversion lasts twelve bit periods minimum
// - Clock select picks 2, 8, 32 or RC
// - RC bit period nominally four microseconds
// - Analog-configured port pins read zero
// - Clearing trigger aborts, result not written unless the clear coincides with completion
// - Abort keeps previous result register contents unless it coincides with completion
// - Abort waits two bit periods, reacquires
// - First segment one bit period, at least one instruction cycle
// - Result loaded justified, unused bits zero
// - Disabled converter leaves result registers plain
// - Sleep conversion only with RC clock
// - Sleep completion clears trigger, may wake
// - Sleep completion without irq powers down
// - Sleep on non-RC clock aborts, powers down
// - Reset clears control registers, aborts conversion
// - Completion loads result, clears trigger, flags
// - Format bit selects right or left justification
`default_nettype none
package adcsq_pkg;
   localparam logic [7:0] ADDR_INTCTL = 8'h0b;
   localparam logic [7:0] ADDR_PFLAGS = 8'h0c;
   localparam logic [7:0] ADDR_RESH = 8'h1e;
   localparam logic [7:0] ADDR_CTRL = 8'h1f;
   localparam logic [7:0] ADDR_PEN = 8'h8c;
   localparam logic [7:0] ADDR_RESL = 8'h9e;
   localparam logic [7:0] ADDR_CFG = 8'h9f;
   localparam logic [7:0] ADDR_PORT = 8'h05;
   localparam int BIT_GIE = 7;
   localparam int BIT_DONE_FLAG = 6;
   localparam int BIT_IRQ_EN = 6;
   localparam int BIT_GO = 2;
   localparam int BIT_ON = 0;
   localparam int BIT_FMT = 7;
   localparam logic [7:0] CTRL_MASK = 8'hfd;
   localparam logic [7:0] CFG_MASK = 8'h8f;
   localparam logic [7:0] RESET_CTRL = 8'h00;
   localparam logic [7:0] RESET_CFG = 8'h00;
   localparam logic [7:0] RESET_PFLAGS = 8'h00;
   localparam logic [7:0] RESET_PEN = 8'h00;
   localparam logic [7:0] RESET_INTCTL = 8'h00;
   localparam logic [1:0] CLKSEL_RC = 2'h3;
   localparam int CLK_MHZ = 20;
   localparam int OSC_2 = 2;
   localparam int OSC_8 = 8;
   localparam int OSC_32 = 32;
   // RC bit period nominal 4 us; modelled with an on-chip tick
   localparam int RC_TAD_NS = 4000;
   localparam int RC_TAD_CYC = RC_TAD_NS * CLK_MHZ / 1000;
   // Instruction cycle is four oscillator periods (200 ns at 20 MHz)
   localparam int TCY_NS = 200;
   localparam int TCY_CYC = TCY_NS * CLK_MHZ / 1000;
   localparam int CONV_TADS = 12;
   localparam int REST_TADS = 2;
   localparam logic [6:0] CNT_W0 = 7'h00;
endpackage
`default_nettype wire

// ===== core/adcsq_core.sv
// Conversion sequencer: registers, bit-period timing, conversion FSM.
// Assumes a synchronous register port and a sampled 10-bit converter code.
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
module adcsq_core
   import adcsq_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic sleep,
   input wire logic [9:0] conv_code,
   input wire logic [7:0] port_pins,
   output logic wake,
   output logic irq_flag_out,
   output logic sample_connect,
   output logic analog_power,
   output logic [2:0] channel_select
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_FIRST = 5'b00010,
      ST_CONV = 5'b00100,
      ST_REST = 5'b01000,
      ST_OFF = 5'b10000
   } adcsq_state_e;

   adcsq_state_e state;
   logic [7:0] ctrl, cfg, pflags, pen, intctl, res_h, res_l;
   logic [6:0] div_cnt;
   logic [3:0] tad_cnt;
   logic tick;
   logic [6:0] next_div;

   function automatic logic [6:0] tad_len(input logic [1:0] sel);
      case (sel)
         2'h0: tad_len = 7'(OSC_2);
         2'h1: tad_len = 7'(OSC_8);
         2'h2: tad_len = 7'(OSC_32);
         default: tad_len = 7'(RC_TAD_CYC);
      endcase
   endfunction

   // Analog pins per pin_config; one bit per port pin, 1 = analog
   function automatic logic [7:0] analog_map(input logic [3:0] pc);
      case (pc)
         4'h0, 4'h1, 4'h8: analog_map = 8'hff;
         4'h2, 4'h3: analog_map = 8'h2f;
         4'h4, 4'h5: analog_map = 8'h0b;
         4'h9, 4'ha, 4'hb: analog_map = 8'h3f;
         4'hc: analog_map = 8'h2f;
         4'hd: analog_map = 8'h0b;
         4'he: analog_map = 8'h01;
         4'hf: analog_map = 8'h09;
         default: analog_map = 8'h00;
      endcase
   endfunction

   wire logic [1:0] clksel = ctrl[7:6];
   wire logic go = ctrl[BIT_GO];
   wire logic on = ctrl[BIT_ON];
   wire logic wr_ctrl = wr && addr == ADDR_CTRL;
   wire logic sw_go_set = wr_ctrl && wdata[BIT_GO] && !go && on;
   wire logic sw_abort = wr_ctrl && !wdata[BIT_GO] &&
      (state == ST_FIRST || state == ST_CONV);
   wire logic sleep_abort = sleep && clksel != CLKSEL_RC;
   wire logic done = state == ST_CONV && tick &&
      tad_cnt == 4'(CONV_TADS - 1);

   // Bit-period divider; restarts on each new sequence so the first
   // segment lasts one bit period, or one instruction cycle when that is longer.
   always_comb begin
      next_div = div_cnt + 7'h01;
      if (state == ST_IDLE || state == ST_OFF)
         next_div = CNT_W0;
      else if (tick)
         next_div = CNT_W0;
      // Abort restarts the divider so the rest lasts two whole bit periods
      else if (sw_abort || (sleep_abort &&
            (state == ST_FIRST || state == ST_CONV)))
         next_div = CNT_W0;
   end
   always_ff @(posedge clk) begin
      if (reset)
         div_cnt <= CNT_W0;
      else
         div_cnt <= next_div;
   end
   // first BIT_PERIOD at least one INSTRUCTION_PERIOD
   assign tick = (state == ST_FIRST) ?
      (div_cnt + 7'h01 >= ((tad_len(clksel) > 7'(TCY_CYC)) ?
         tad_len(clksel) : 7'(TCY_CYC))) :
      (div_cnt + 7'h01 >= tad_len(clksel));

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= ST_IDLE;
         tad_cnt <= 4'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               tad_cnt <= 4'h0;
               if (sw_go_set && !sleep_abort)
                  state <= ST_FIRST;
            end
            ST_FIRST: begin
               if (sw_abort || sleep_abort) begin
                  state <= ST_REST;
                  tad_cnt <= 4'h0;
               end else if (tick) begin
                  state <= ST_CONV;
                  tad_cnt <= 4'h1;
               end
            end
            ST_CONV: begin
               if (sw_abort || sleep_abort) begin
                  state <= ST_REST;
                  tad_cnt <= 4'h0;
               end else if (done) begin
                  state <= ST_REST;
                  tad_cnt <= 4'h0;
               end else if (tick)
                  tad_cnt <= tad_cnt + 4'h1;
            end
            ST_REST: begin
               if (tick) begin
                  tad_cnt <= tad_cnt + 4'h1;
                  if (tad_cnt == 4'(REST_TADS - 1))
                     state <= (sleep && !(pen[BIT_IRQ_EN]))
                        ? ST_OFF : ST_IDLE;
               end
            end
            ST_OFF: begin
               if (!sleep)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Control register; completion clear of GO wins over a software write
   always_ff @(posedge clk) begin
      if (reset)
         ctrl <= RESET_CTRL;
      else if (wr_ctrl) begin
         ctrl <= wdata & CTRL_MASK;
         if (!on)
            ctrl[BIT_GO] <= 1'b0;
         if (done)
            ctrl[BIT_GO] <= 1'b0;
      end else if (done || (sleep_abort && go))
         ctrl[BIT_GO] <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg <= RESET_CFG;
         pen <= RESET_PEN;
         intctl <= RESET_INTCTL;
      end else if (wr) begin
         if (addr == ADDR_CFG)
            cfg <= wdata & CFG_MASK;
         if (addr == ADDR_PEN)
            pen <= wdata;
         if (addr == ADDR_INTCTL)
            intctl <= wdata;
      end
   end

   // Flag set wins over a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset)
         pflags <= RESET_PFLAGS;
      else begin
         if (wr && addr == ADDR_PFLAGS)
            pflags <= wdata;
         if (done)
            pflags[BIT_DONE_FLAG] <= 1'b1;
      end
   end

   // Result pair: no reset; completion beats a software write
   always_ff @(posedge clk) begin
      if (done) begin
         if (cfg[BIT_FMT]) begin
            res_h <= {6'h00, conv_code[9:8]};
            res_l <= conv_code[7:0];
         end else begin
            res_h <= conv_code[9:2];
            res_l <= {conv_code[1:0], 6'h00};
         end
      end else if (wr && addr == ADDR_RESH)
         res_h <= wdata;
      else if (wr && addr == ADDR_RESL)
         res_l <= wdata;
   end

   always_ff @(posedge clk) begin
      if (reset)
         rdata <= 8'h00;
      else if (rd) begin
         case (addr)
            ADDR_INTCTL: rdata <= intctl;
            ADDR_PFLAGS: rdata <= pflags;
            ADDR_RESH: rdata <= res_h;
            ADDR_CTRL: rdata <= ctrl;
            ADDR_PEN: rdata <= pen;
            ADDR_RESL: rdata <= res_l;
            ADDR_CFG: rdata <= cfg;
            ADDR_PORT: rdata <= port_pins & ~analog_map(cfg[3:0]);
            default: rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wake <= 1'b0;
         irq_flag_out <= 1'b0;
         sample_connect <= 1'b0;
         analog_power <= 1'b0;
         channel_select <= 3'h0;
      end else begin
         wake <= sleep && done && pen[BIT_IRQ_EN];
         irq_flag_out <= pflags[BIT_DONE_FLAG] || done;
         // hold capacitor off during rest and conversion
         sample_connect <= on && state == ST_IDLE && !sleep_abort;
         analog_power <= on && state != ST_OFF && !sleep_abort;
         channel_select <= ctrl[5:3];
      end
   end

   // Assertions
   int unsigned conv_len;
   always_ff @(posedge clk) begin
      if (reset || state != ST_CONV)
         conv_len <= 0;
      else
         conv_len <= conv_len + 1;
   end

   sequence s_done;
      done;
   endsequence
   sequence s_rest_two;
      (state == ST_REST) [*2];
   endsequence

   a_done_clears_go: assert property (@(posedge clk) disable iff (reset)
      s_done |=> !go)
      else $error("trigger not cleared at completion");
   a_done_sets_flag: assert property (@(posedge clk) disable iff (reset)
      s_done |=> pflags[BIT_DONE_FLAG])
      else $error("done flag not set");
   a_conv_min_len: assert property (@(posedge clk) disable iff (reset)
      done |-> conv_len + 1 >= 11 * OSC_2)
      else $error("conversion too short");
   a_done_then_rest: assert property (@(posedge clk) disable iff (reset)
      s_done |=> s_rest_two)
      else $error("no rest after conversion");
   a_abort_no_load: assert property (@(posedge clk) disable iff (reset)
      sw_abort && !done |=> $stable(res_h) && $stable(res_l))
      else $error("aborted conversion wrote result");
   a_abort_to_rest: assert property (@(posedge clk) disable iff (reset)
      sw_abort |=> state == ST_REST)
      else $error("abort did not enter rest");
   a_right_justify: assert property (@(posedge clk) disable iff (reset)
      done && cfg[BIT_FMT] |=> res_h[7:2] == 6'h00)
      else $error("right justify upper bits not zero");
   a_left_justify: assert property (@(posedge clk) disable iff (reset)
      done && !cfg[BIT_FMT] |=> res_l[5:0] == 6'h00)
      else $error("left justify lower bits not zero");
   a_go_needs_on: assert property (@(posedge clk) disable iff (reset)
      state == ST_IDLE ##1 state == ST_FIRST |-> on)
      else $error("conversion started while off");
   a_sleep_nonrc: assert property (@(posedge clk) disable iff (reset)
      sleep_abort && state == ST_CONV |=> state == ST_REST)
      else $error("sleep did not abort non-RC conversion");
endmodule
`default_nettype wire

// ===== dv/adcsq_analog_model.sv
// Analog source model: one input level, a hold capacitor, port pins.
// Assumes the bench sets the level and the block drives sample_connect.
`default_nettype none
module adcsq_analog_model (
   input wire logic clk,
   input wire logic [9:0] level,
   input wire logic sample_connect,
   output logic [9:0] conv_code,
   output logic [7:0] port_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pin is an input, so the cap sees the level only while connected
   always_ff @(posedge clk) begin
      if (sample_connect) begin
         conv_code <= level;
      end
   end
   assign port_pins = level[9:2];
endmodule
`default_nettype wire

// ===== dv/test_adc_conversion_sequencer.sv
// Bench for the conversion sequencer: register master and result model.
// Assumes the analog model feeds the converter code and the port pins.
`default_nettype none
module test_adc_conversion_sequencer
   import adcsq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, wr, rd, sleep, wake, irq_flag_out;
   logic sample_connect, analog_power, wake_seen;
   logic [7:0] addr, wdata, rdata, port_pins, d, rh, rl;
   logic [9:0] level, conv_code;
   logic [2:0] channel_select;
   logic [15:0] lfsr, exp_res;
   int n_errors, tests_run, n;
   int bit_period[4] = '{OSC_2, OSC_8, OSC_32, RC_TAD_CYC};
   logic [7:0] ra[6] = '{ADDR_CTRL, ADDR_CFG, ADDR_PFLAGS, ADDR_PEN,
      ADDR_INTCTL, 8'h40};

   adcsq_core dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep),
      .conv_code(conv_code), .port_pins(port_pins), .wake(wake),
      .irq_flag_out(irq_flag_out), .sample_connect(sample_connect),
      .analog_power(analog_power), .channel_select(channel_select));
   adcsq_analog_model model_u (.clk(clk), .level(level),
      .sample_connect(sample_connect), .conv_code(conv_code),
      .port_pins(port_pins));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Wake is a one-cycle pulse, so latch it
   always @(posedge clk) if (wake === 1'b1) wake_seen <= 1'b1;

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
         input string msg);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg,
            got, exp);
      end
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_hi(input bit s, input int lim, output int c);
      c = 0;
      while ((s ? sample_connect : irq_flag_out) !== 1'b1) begin
         @(posedge clk);
         #1 c++;
         if (c > lim) begin
            n_errors++;
            $display("unexpected at %0t: wait ran out", $time);
            test_done();
         end
      end
   endtask
   task automatic conv(input int sel, input bit fmt, input bit slp,
         input bit ien);
      logic [7:0] ctl;
      ctl = {sel[1:0], sel[2:0], 3'b001};
      lfsr = lfsr_next(lfsr);
      wr_reg(ADDR_CFG, {fmt, 7'h00});
      wr_reg(ADDR_CTRL, ctl);
      level <= lfsr[9:0];
      repeat (400) @(posedge clk);
      wake_seen = 1'b0;
      exp_res = fmt ? {6'h00, lfsr[9:0]} : {lfsr[9:0], 6'h00};
      wr_reg(ADDR_CTRL, ctl | 8'h04);
      sleep <= slp;
      // Moving the level mid-conversion shows whether the cap is isolated
      repeat (8) @(posedge clk);
      level <= ~lfsr[9:0];
      wait_hi(0, 13 * bit_period[sel] + 8, n);
      chk(n + 8 >= 12 * bit_period[sel], 1, "conversion too short");
      repeat (bit_period[sel]) @(posedge clk);
      #1 chk(sample_connect, 0, "rest");
      chk(wake_seen, slp && ien, "wake");
      // Power-down follows only once the two-period rest is over
      repeat (bit_period[sel] + 4) @(posedge clk);
      #1 chk(analog_power, !(slp && !ien), "power");
      if (!slp) wait_hi(1, 2 * bit_period[sel] + 6, n);
      sleep <= 1'b0;
      rd_reg(ADDR_CTRL, d);
      chk(d, ctl, "control after done");
      rd_reg(ADDR_PFLAGS, d);
      chk(d[6], 1, "done flag");
      rd_reg(ADDR_RESH, rh);
      rd_reg(ADDR_RESL, rl);
      chk({rh, rl}, exp_res, "result");
      wr_reg(ADDR_PFLAGS, 8'h00);
      $display("conversion sel %0d fmt %0d sleep %0d ends", sel, fmt, slp);
   endtask

   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      sleep = 1'b0;
      level = 10'h2a5;
      wake_seen = 1'b0;
      lfsr = 16'h406b;
      n_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      foreach (ra[i]) begin
         rd_reg(ra[i], d);
         chk(d, 0, "reset value");
      end
      wr_reg(ADDR_CTRL, 8'h04);
      rd_reg(ADDR_CTRL, d);
      chk(d, 0, "go while off");
      rd_reg(ADDR_PORT, d);
      chk(d, 0, "analog pins");
      wr_reg(ADDR_CFG, 8'h06);
      rd_reg(ADDR_PORT, d);
      chk(d, 8'ha9, "digital pins");
      $display("register checks end");
      for (int s = 0; s < 4; s++) begin
         conv(s, s[0], 0, 0);
      end
      wr_reg(ADDR_PEN, 8'h40);
      conv(3, 0, 1, 1);
      wr_reg(ADDR_PEN, 8'h00);
      conv(3, 1, 1, 0);
      wr_reg(ADDR_CTRL, 8'h00);
      wr_reg(ADDR_RESH, 8'ha5);
      wr_reg(ADDR_RESL, 8'h3c);
      rd_reg(ADDR_RESH, rh);
      rd_reg(ADDR_RESL, rl);
      chk({rh, rl}, 16'ha53c, "plain storage");
      wr_reg(ADDR_CTRL, 8'h81);
      repeat (400) @(posedge clk);
      wr_reg(ADDR_CTRL, 8'h85);
      repeat (60) @(posedge clk);
      wr_reg(ADDR_CTRL, 8'h81);
      #1 chk(sample_connect, 0, "abort hold");
      wait_hi(1, 2 * OSC_32 + 6, n);
      chk(n >= 2 * OSC_32 - 3, 1, "abort rest");
      rd_reg(ADDR_RESH, rh);
      rd_reg(ADDR_RESL, rl);
      chk({rh, rl}, 16'ha53c, "abort result");
      rd_reg(ADDR_PFLAGS, d);
      chk(d[6], 0, "abort flag");
      $display("abort test ends");
      wr_reg(ADDR_CTRL, 8'h45);
      repeat (20) @(posedge clk);
      sleep <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(analog_power, 0, "sleep power");
      sleep <= 1'b0;
      rd_reg(ADDR_CTRL, d);
      chk(d, 8'h41, "sleep abort");
      $display("sleep abort test ends");
      wr_reg(ADDR_CTRL, 8'h85);
      repeat (30) @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 chk(analog_power, 0, "reset power");
      rd_reg(ADDR_CTRL, d);
      chk(d, 0, "reset control");
      rd_reg(ADDR_RESH, rh);
      rd_reg(ADDR_RESL, rl);
      chk({rh, rl}, 16'ha53c, "reset result");
      $display("reset test ends");
      test_done();
   end
endmodule
`default_nettype wire
